// *** include/tsd_consts.svh ***
/*
 * constants of the divider chain: register byte offsets, field positions,
 * reset values and fixed counts.
 * assumes inclusion by bare name from the design files.
 */
// Operation
// - crystal reference divided by programmable ratio feeds both post-scale selectors
// - main post-scaler divides by 1, 2 or 4; code 01 is 4, 00 is 1
// - auxiliary post-scaler passes reference output undivided on code 00
// - auxiliary ratio reaches 3600 at least; 7200 is out of range
// - total main division equals (down load + up limit) times low ratio plus up limit
// - up-count limit of zero counts 256
// - prescaler low ratio by default, high ratio for up-limit cycles
// - fraction modulus select 1 works in eighths
// - 12-bit main counter, down load 3 to 4095, 8-bit up limit
// - one counter: load, count down to zero, up to limit, reload; control high then low
// - accumulator overflow forces high ratio on last down count
// - zero numerator forces accumulator to zero
`ifndef TSD_CONSTS_SVH
`define TSD_CONSTS_SVH

// register byte offsets
`define TSD_OFS_REF_CTRL    5'h00
`define TSD_OFS_AUX_RATIO   5'h04
`define TSD_OFS_MAIN_RATIO  5'h08
`define TSD_OFS_FRAC_CTRL   5'h0c
`define TSD_OFS_STATUS      5'h10

// field positions
`define TSD_POS_MAIN_PS     16
`define TSD_POS_AUX_PS      20
`define TSD_POS_UP_LIMIT    16
`define TSD_POS_FRAC_MODSEL 4
`define TSD_POS_FRAC_EN     8
`define TSD_POS_ST_PHASE    12
`define TSD_POS_ST_MOD      13
`define TSD_POS_ST_ACC      16

// reset values
`define TSD_RST_REF_RATIO   12'h129
`define TSD_RST_MAIN_PS     2'h1
`define TSD_RST_AUX_PS      2'h0
`define TSD_RST_AUX_RATIO   12'h708
`define TSD_RST_DOWN_LOAD   12'h4c8
`define TSD_RST_UP_LIMIT    8'h01

// counts
`define TSD_DOWN_MIN        12'h003
`define TSD_UP_ZERO_COUNT   9'h100
`define TSD_FRAC_MOD_EIGHTHS 4'h8
`define TSD_FRAC_MOD_FIFTHS 4'h5

`endif

// *** include/tsd_pkg.sv ***
/*
 * types of the divider chain: counter phase and the state records.
 * assumes tsd_consts.svh supplies all numbers.
 */
package tsd_pkg;

	typedef enum logic {
		TSD_PH_DOWN,
		TSD_PH_UP
	} tsd_phase_t;

	typedef struct packed {
		logic [11:0] cnt;
		logic        pulse;
	} tsd_div_state_t;

	typedef struct packed {
		logic        fim_sync1;
		logic        fim_sync2;
		logic        fim_prev;
		logic        aux_sync1;
		logic        aux_sync2;
		logic        aux_prev;
		tsd_phase_t  phase;
		logic [11:0] cnt;
		logic [11:0] n1_act;
		logic [8:0]  n2_act;
		logic [2:0]  acc;
		logic [2:0]  num_act;
		logic        mod8_act;
		logic        frac_on;
		logic        ovf_pend;
		logic        mod_out;
		logic        main_pulse;
		logic [11:0] ref_ratio;
		logic [1:0]  main_ps;
		logic [1:0]  aux_ps;
		logic [11:0] aux_ratio;
		logic [11:0] down_load;
		logic [7:0]  up_limit;
		logic [2:0]  frac_num;
		logic        frac_modsel;
		logic        frac_en;
		logic        ack;
		logic [31:0] rdata;
	} tsd_main_state_t;

endpackage

// *** hdl/tsd_pulse_div.sv ***
/*
 * generic 12-bit pulse divider: one output pulse per ratio input ticks.
 * assumes tick_in is a one-cycle pulse on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module tsd_pulse_div (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        tick_in,
	input  wire logic [11:0] ratio,
	output logic             pulse_out
);

	tsd_pkg::tsd_div_state_t s_reg;
	tsd_pkg::tsd_div_state_t s_next;

	// count ticks down, reload the ratio only at the end of a period
	always_comb begin
		s_next = s_reg;
		s_next.pulse = 1'b0;
		if (tick_in) begin
			if (s_reg.cnt <= 12'h001) begin
				s_next.pulse = 1'b1;
				s_next.cnt = ratio;
			end else begin
				s_next.cnt = s_reg.cnt - 12'h001;
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pulse_out = s_reg.pulse;

endmodule // tsd_pulse_div

`default_nettype wire

// *** hdl/tsd_divider_chain.sv ***
/*
 * divider chain of a twin synthesiser: reference divider with two
 * post-scalers, auxiliary feedback divider, main up/down divider with
 * modulus control and fractional accumulator, Avalon-MM register slave.
 * assumes sys_clk is the crystal reference and both prescaler outputs are
 * asynchronous pins slower than a quarter of sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tsd_consts.svh"

module tsd_divider_chain (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        main_prescale_in,
	input  wire logic        aux_vco_in,
	output logic             modulus_control_pos,
	output logic             modulus_control_neg,
	output logic             main_cmp_pulse,
	output logic             aux_cmp_pulse,
	output logic             main_div_pulse,
	output logic             aux_div_pulse
);

	tsd_pkg::tsd_main_state_t s_reg;
	tsd_pkg::tsd_main_state_t s_next;
	logic                     ref_pulse;
	logic                     fim_tick;
	logic                     aux_tick;

	// byte-enable merge of a register write
	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// post-scale selector code to divide ratio
	function automatic logic [11:0] post_ratio(input logic [1:0] code);
		logic [11:0] r;
		r = 12'h001;
		if (code == 2'h1) begin
			r = 12'h004;
		end else if (code == 2'h2) begin
			r = 12'h002;
		end
		return r;
	endfunction

	// reference divider and its two post-scalers
	tsd_pulse_div u_ref_div (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.tick_in   (1'b1),
		.ratio     (s_reg.ref_ratio),
		.pulse_out (ref_pulse)
	);

	tsd_pulse_div u_main_post (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.tick_in   (ref_pulse),
		.ratio     (post_ratio(s_reg.main_ps)),
		.pulse_out (main_cmp_pulse)
	);

	tsd_pulse_div u_aux_post (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.tick_in   (ref_pulse),
		.ratio     (post_ratio(s_reg.aux_ps)),
		.pulse_out (aux_cmp_pulse)
	);

	// auxiliary feedback divider, 12-bit ratio up to 4095
	tsd_pulse_div u_aux_fb (
		.sys_clk   (sys_clk),
		.rst_b     (rst_b),
		.tick_in   (aux_tick),
		.ratio     (s_reg.aux_ratio),
		.pulse_out (aux_div_pulse)
	);

	// rising edges of the synchronised prescaler pins
	assign fim_tick = s_reg.fim_sync2 & ~s_reg.fim_prev;
	assign aux_tick = s_reg.aux_sync2 & ~s_reg.aux_prev;

	// next state: synchronisers, bus slave, main counter, accumulator
	always_comb begin
		logic [3:0]  sum;
		logic [3:0]  modv;
		logic [31:0] w;
		sum = 4'h0;
		modv = 4'h0;
		w = 32'h0;
		s_next = s_reg;
		s_next.main_pulse = 1'b0;
		s_next.fim_sync1 = main_prescale_in;
		s_next.fim_sync2 = s_reg.fim_sync1;
		s_next.fim_prev = s_reg.fim_sync2;
		s_next.aux_sync1 = aux_vco_in;
		s_next.aux_sync2 = s_reg.aux_sync1;
		s_next.aux_prev = s_reg.aux_sync2;

		// one wait cycle, then the access completes
		s_next.ack = (avs_read | avs_write) & ~s_reg.ack;
		if (avs_read && !s_reg.ack) begin
			if (avs_address == `TSD_OFS_REF_CTRL) begin
				s_next.rdata = {10'h0, s_reg.aux_ps, 2'h0, s_reg.main_ps, 4'h0, s_reg.ref_ratio};
			end else if (avs_address == `TSD_OFS_AUX_RATIO) begin
				s_next.rdata = {20'h0, s_reg.aux_ratio};
			end else if (avs_address == `TSD_OFS_MAIN_RATIO) begin
				s_next.rdata = {8'h0, s_reg.up_limit, 4'h0, s_reg.down_load};
			end else if (avs_address == `TSD_OFS_FRAC_CTRL) begin
				s_next.rdata = {23'h0, s_reg.frac_en, 3'h0, s_reg.frac_modsel, 1'b0, s_reg.frac_num};
			end else if (avs_address == `TSD_OFS_STATUS) begin
				s_next.rdata = {13'h0, s_reg.acc, 2'h0, s_reg.mod_out, s_reg.phase == tsd_pkg::TSD_PH_UP, s_reg.cnt};
			end else begin
				s_next.rdata = 32'h0; // unmapped reads zero
			end
		end
		if (avs_write && s_reg.ack) begin
			if (avs_address == `TSD_OFS_REF_CTRL) begin
				w = wmerge({10'h0, s_reg.aux_ps, 2'h0, s_reg.main_ps, 4'h0, s_reg.ref_ratio}, avs_writedata, avs_byteenable);
				s_next.ref_ratio = w[11:0];
				s_next.main_ps = w[`TSD_POS_MAIN_PS +: 2];
				s_next.aux_ps = w[`TSD_POS_AUX_PS +: 2];
			end else if (avs_address == `TSD_OFS_AUX_RATIO) begin
				w = wmerge({20'h0, s_reg.aux_ratio}, avs_writedata, avs_byteenable);
				s_next.aux_ratio = w[11:0];
			end else if (avs_address == `TSD_OFS_MAIN_RATIO) begin
				w = wmerge({8'h0, s_reg.up_limit, 4'h0, s_reg.down_load}, avs_writedata, avs_byteenable);
				s_next.down_load = w[11:0];
				s_next.up_limit = w[`TSD_POS_UP_LIMIT +: 8];
			end else if (avs_address == `TSD_OFS_FRAC_CTRL) begin
				w = wmerge({23'h0, s_reg.frac_en, 3'h0, s_reg.frac_modsel, 1'b0, s_reg.frac_num}, avs_writedata, avs_byteenable);
				s_next.frac_num = w[2:0];
				s_next.frac_modsel = w[`TSD_POS_FRAC_MODSEL];
				s_next.frac_en = w[`TSD_POS_FRAC_EN];
			end
		end

		// main counter: N1 cycles at low ratio, then N2 cycles at high ratio
		if (fim_tick) begin
			if (s_reg.phase == tsd_pkg::TSD_PH_DOWN) begin
				if (s_reg.cnt <= 12'h001) begin
					s_next.phase = tsd_pkg::TSD_PH_UP;
					s_next.cnt = 12'h000;
				end else begin
					s_next.cnt = s_reg.cnt - 12'h001;
				end
			end else if (12'(s_reg.cnt + 12'h001) >= {3'h0, s_reg.n2_act}) begin
				// period done, total (N1+N2)*low + N2 prescaler input cycles
				s_next.phase = tsd_pkg::TSD_PH_DOWN;
				s_next.main_pulse = 1'b1;
				// latch new settings only here, so no partial period
				s_next.n1_act = (s_reg.down_load < `TSD_DOWN_MIN) ? `TSD_DOWN_MIN : s_reg.down_load;
				s_next.n2_act = (s_reg.up_limit == 8'h00) ? `TSD_UP_ZERO_COUNT : {1'b0, s_reg.up_limit};
				s_next.cnt = s_next.n1_act;
				s_next.num_act = s_reg.frac_num;
				s_next.mod8_act = s_reg.frac_modsel;
				s_next.frac_on = s_reg.frac_en;
				// fraction accumulator, one step per comparison period
				modv = s_reg.frac_modsel ? `TSD_FRAC_MOD_EIGHTHS : `TSD_FRAC_MOD_FIFTHS;
				sum = {1'b0, s_reg.acc} + {1'b0, s_reg.frac_num};
				s_next.ovf_pend = 1'b0;
				if (!s_reg.frac_en || s_reg.frac_num == 3'h0) begin
					s_next.acc = 3'h0;
				end else if (sum >= modv) begin
					s_next.acc = 3'(sum - modv);
					s_next.ovf_pend = 1'b1;
				end else begin
					s_next.acc = sum[2:0];
				end
			end else begin
				s_next.cnt = s_reg.cnt + 12'h001;
			end
		end

		// high during down count, low during up count and on an overflow's last down count
		s_next.mod_out = (s_next.phase == tsd_pkg::TSD_PH_DOWN) && !(s_next.ovf_pend && s_next.cnt == 12'h001);
	end

	// state register with reset values
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			s_reg <= '0;
			s_reg.ref_ratio <= `TSD_RST_REF_RATIO;
			s_reg.main_ps <= `TSD_RST_MAIN_PS;
			s_reg.aux_ps <= `TSD_RST_AUX_PS;
			s_reg.aux_ratio <= `TSD_RST_AUX_RATIO;
			s_reg.down_load <= `TSD_RST_DOWN_LOAD;
			s_reg.up_limit <= `TSD_RST_UP_LIMIT;
			s_reg.n1_act <= `TSD_DOWN_MIN;
			s_reg.n2_act <= {1'b0, `TSD_RST_UP_LIMIT};
			s_reg.cnt <= `TSD_DOWN_MIN;
			s_reg.mod_out <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// outputs
	assign avs_waitrequest = (avs_read | avs_write) & ~s_reg.ack;
	assign avs_readdata = s_reg.rdata;
	assign modulus_control_pos = s_reg.mod_out;
	assign modulus_control_neg = ~s_reg.mod_out;
	assign main_div_pulse = s_reg.main_pulse;

	// checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence s_last_down;
		fim_tick && s_reg.phase == tsd_pkg::TSD_PH_DOWN && s_reg.cnt == 12'h001;
	endsequence

	sequence s_up_end;
		fim_tick && s_reg.phase == tsd_pkg::TSD_PH_UP && 12'(s_reg.cnt + 12'h001) == {3'h0, s_reg.n2_act};
	endsequence

	AST_DOWN_TO_UP: assert property (s_last_down |=> s_reg.phase == tsd_pkg::TSD_PH_UP && s_reg.cnt == 12'h000 && !s_reg.mod_out)
		else $error("down count did not turn to up count");
	AST_RELOAD: assert property (s_up_end |=> s_reg.phase == tsd_pkg::TSD_PH_DOWN && s_reg.cnt == s_reg.n1_act && main_div_pulse)
		else $error("up count end did not reload");
	AST_UP_BOUND: assert property (s_reg.phase == tsd_pkg::TSD_PH_UP |-> s_reg.cnt < {3'h0, s_reg.n2_act} && s_reg.n2_act <= 9'h100)
		else $error("up count beyond its limit");
	AST_UP_HIGH_RATIO: assert property (s_reg.phase == tsd_pkg::TSD_PH_UP |-> !modulus_control_pos && modulus_control_neg)
		else $error("modulus control high during up count");
	AST_DOWN_MIN: assert property (s_reg.n1_act >= `TSD_DOWN_MIN)
		else $error("down load below three");
	AST_PULSE_SINGLE: assert property (main_div_pulse |=> !main_div_pulse)
		else $error("main pulse longer than one cycle");
	AST_ZERO_NUM: assert property (main_div_pulse && s_reg.num_act == 3'h0 |-> s_reg.acc == 3'h0 && !s_reg.ovf_pend)
		else $error("accumulator not cleared");
	AST_OVF_LAST: assert property (s_reg.ovf_pend && s_reg.phase == tsd_pkg::TSD_PH_DOWN && s_reg.cnt == 12'h001 |-> !modulus_control_pos)
		else $error("overflow did not force high ratio");
	AST_EIGHTHS: assert property (s_up_end ##0 (s_reg.frac_en && s_reg.frac_modsel && s_reg.frac_num != 3'h0) |=>
		s_reg.acc == 3'($past(s_reg.acc) + $past(s_reg.frac_num)))
		else $error("accumulator not modulo eight");
	AST_BUS_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer later than one cycle");

endmodule // tsd_divider_chain

`default_nettype wire

// *** tb/tsd_prescaler_model.sv ***
/*
 * two-modulus prescaler model fed by a behavioural vco; keeps a running
 * count of vco cycles and of periods spent at the high ratio.
 * assumes modulus control comes from the divider chain pins.
 */
`timescale 1ns/1ps
`default_nettype none

module tsd_prescaler_model #(
	parameter int LOW_RATIO = 8
) (
	input  wire logic       modulus_control_pos,
	input  wire logic       modulus_control_neg,
	output var logic        prescale_out,
	output var logic [31:0] vco_count,
	output var logic [31:0] fast_count
);
	logic vco;
	int   phase_cnt;
	int   ratio;

	// start at the low ratio with counts cleared
	initial begin
		vco = 1'b0;
		phase_cnt = 0;
		ratio = LOW_RATIO;
		prescale_out = 1'b0;
		vco_count = 32'h0;
		fast_count = 32'h0;
	end

	// free-running vco, phase unrelated to sys_clk
	always #37 vco = ~vco;

	// ratio picked at each output rise; counts only move at that rise
	always @(posedge vco) begin
		if (phase_cnt == 0) begin
			ratio = (modulus_control_pos && !modulus_control_neg) ? LOW_RATIO : LOW_RATIO + 1;
			vco_count <= vco_count + 32'(ratio);
			fast_count <= fast_count + ((ratio == LOW_RATIO) ? 32'h0 : 32'h1);
			prescale_out <= 1'b1;
		end
		if (phase_cnt == ratio / 2)
			prescale_out <= 1'b0;
		phase_cnt = (phase_cnt + 1 == ratio) ? 0 : phase_cnt + 1;
	end
endmodule // tsd_prescaler_model

`default_nettype wire

// *** tb/tb.sv ***
/*
 * self-checking bench of the divider chain: register access over avalon,
 * divider periods measured against the programmed ratios.
 * assumes the prescaler model and a free-running aux vco on the far side.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tsd_consts.svh"

`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin bad_count++; \
	$display("CHECK FAILED %s expected %0d seen %0d", nm, ex, gt); end end

module tb;
	localparam int LOW = 8;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [4:0]  avs_address = 5'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0]  avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        prescale_pin;
	logic        aux_vco_in = 1'b0;
	logic        mod_pos;
	logic        mod_neg;
	logic [3:0]  pulses;
	logic [31:0] vco_count;
	logic [31:0] fast_count;
	logic [31:0] aux_edges = 32'h0;
	logic [31:0] rd;
	logic [31:0] snap;
	logic [31:0] snap_fast;
	int          bad_count = 0;
	int          checks = 0;
	int          t;
	int          n2e;
	int          ntot = 1225 * LOW + 1;
	int          ps[3] = '{1, 4, 2};
	int          n1s[5] = '{5, 3, 4, 10, 5};
	int          n2s[5] = '{3, 1, 0, 255, 3};
	int          nums[4] = '{2, 6, 2, 0};
	int          mods[4] = '{1, 1, 0, 1};
	int          lens[4] = '{8, 8, 5, 8};
	int          ar[2] = '{5, 3600};

	// clocks of the bench and the aux vco
	always #50 sys_clk = ~sys_clk;
	always #313 aux_vco_in = ~aux_vco_in; // edges meet a sys_clk edge only on every 50th toggle
	always @(posedge aux_vco_in) aux_edges <= aux_edges + 32'h1;

	tsd_divider_chain dut (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .main_prescale_in(prescale_pin),
		.aux_vco_in(aux_vco_in), .modulus_control_pos(mod_pos), .modulus_control_neg(mod_neg),
		.main_cmp_pulse(pulses[0]), .aux_cmp_pulse(pulses[1]), .main_div_pulse(pulses[2]),
		.aux_div_pulse(pulses[3]));

	tsd_prescaler_model #(.LOW_RATIO(LOW)) prescaler (.modulus_control_pos(mod_pos),
		.modulus_control_neg(mod_neg), .prescale_out(prescale_pin), .vco_count(vco_count),
		.fast_count(fast_count));

	// one bus transfer, held until waitrequest is seen low
	task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge sys_clk);
		avs_address <= a;
		avs_write <= wr_en;
		avs_read <= !wr_en;
		avs_writedata <= d;
		n = 0;
		// waitrequest and readdata are read at the edge, before the slave updates
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		if (n == 100)
			bad_count++;
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rdchk(input string nm, input logic [4:0] a, input logic [31:0] ex);
		bus(1'b0, a, 32'h0, rd);
		`CHK(nm, ex, rd)
	endtask

	// cycles until the chosen pulse is next seen
	task automatic wait_pulse(input int sel, output int n);
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (pulses[sel] !== 1'b1 && n < 40000);
		if (n == 40000)
			bad_count++;
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// hang guard
	initial begin
		#9000000;
		bad_count++;
		$display("CHECK FAILED watchdog expected 0 seen 1");
		results();
	end

	// main sequence
	initial begin
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		rdchk("ref ctrl", `TSD_OFS_REF_CTRL, 32'h0001_0129);
		rdchk("aux ratio", `TSD_OFS_AUX_RATIO, 32'h0000_0708);
		rdchk("main ratio", `TSD_OFS_MAIN_RATIO, 32'h0001_04c8);
		rdchk("frac ctrl", `TSD_OFS_FRAC_CTRL, 32'h0000_0000);
		rdchk("unmapped", 5'h14, 32'h0000_0000);
		repeat (2) wait_pulse(0, t);
		`CHK("main cmp", 1188, t)
		repeat (2) wait_pulse(1, t);
		`CHK("aux cmp", 297, t)
		for (int c = 0; c < 3; c++) begin
			wr(`TSD_OFS_REF_CTRL, 32'h5 | (32'(c) << `TSD_POS_MAIN_PS));
			repeat (3) wait_pulse(0, t);
			`CHK("main cmp", 5 * ps[c], t)
		end
		repeat (3) wait_pulse(1, t);
		`CHK("aux cmp", 5, t)
		$display("test reference done");
		for (int i = 0; i < 5; i++) begin
			wait_pulse(2, t);
			snap = vco_count;
			wr(`TSD_OFS_MAIN_RATIO, (32'(n2s[i]) << `TSD_POS_UP_LIMIT) | 32'(n1s[i]));
			wait_pulse(2, t);
			`CHK("held total", ntot, vco_count - snap)
			snap = vco_count;
			snap_fast = fast_count;
			wait_pulse(2, t);
			n2e = (n2s[i] == 0) ? 256 : n2s[i];
			ntot = (n1s[i] + n2e) * LOW + n2e;
			`CHK("main total", ntot, vco_count - snap)
			`CHK("high ratio periods", n2e, fast_count - snap_fast)
		end
		$display("test main divider done");
		for (int i = 0; i < 4; i++) begin
			wr(`TSD_OFS_FRAC_CTRL, 32'(nums[i]) | (32'(mods[i]) << `TSD_POS_FRAC_MODSEL) | (32'h1 << `TSD_POS_FRAC_EN));
			repeat (3) wait_pulse(2, t);
			snap = vco_count;
			repeat (lens[i]) wait_pulse(2, t);
			`CHK("fraction total", lens[i] * ntot + nums[i], vco_count - snap)
		end
		bus(1'b0, `TSD_OFS_STATUS, 32'h0, rd);
		`CHK("accumulator", 3'h0, rd[`TSD_POS_ST_ACC +: 3])
		$display("test fraction done");
		for (int i = 0; i < 2; i++) begin
			wait_pulse(3, t);
			wr(`TSD_OFS_AUX_RATIO, 32'(ar[i]));
			wait_pulse(3, t);
			snap = aux_edges;
			wait_pulse(3, t);
			`CHK("aux edges", ar[i], aux_edges - snap)
		end
		rdchk("aux ratio", `TSD_OFS_AUX_RATIO, 32'h0000_0e10);
		// only the low byte lane of this write may land
		avs_byteenable <= 4'h1;
		wr(`TSD_OFS_AUX_RATIO, 32'hffff_ffff);
		avs_byteenable <= 4'hf;
		rdchk("aux ratio byte lane", `TSD_OFS_AUX_RATIO, 32'h0000_0eff);
		$display("test aux divider done");
		results();
	end
endmodule // tb

`default_nettype wire
